/* shsp_serial_port.sv */
`timescale 1ns/1ps
module shsp_serial_port
   import shsp_pkg::*;
(
   // system
   input  wire logic     ref_clk,
   input  wire logic     reset_n,
   // spi pins, serial_clock_in clocks the link domain
   input  wire logic     serial_clock_in,
   input  wire logic     chip_select_n,
   input  wire logic     spi_data_in,
   output logic          spi_data_out,
   output logic          spi_data_oe,
   // i2c pins and straps
   input  wire logic     scl_in,
   input  wire logic     sda_in,
   output logic          sda_out,
   output logic          sda_oe,
   input  wire logic     addr_strap_0,
   input  wire logic     addr_strap_1,
   // register file, ref_clk side
   output logic          wr_en,
   output shsp_wr_t      wr,
   output logic [6:0]    rd_addr,
   input  wire logic [7:0] rd_data,
   output logic          i2c_mode,
   // register file, asynchronous read port for the spi link
   output logic [6:0]    link_rd_addr,
   input  wire logic [7:0] link_rd_data
);

   ////////////////////////////////////////////////////////////////////////////
   // spi link domain; chip select high holds the frame logic in reset
   wire link_rst_n = reset_n & ~chip_select_n;

   logic [2:0] spi_bit;
   logic       spi_hdr;
   logic       spi_rw;
   logic       spi_sel;
   logic       spi_wdone;
   logic [6:0] spi_addr;
   logic [6:0] spi_sh;
   logic [7:0] spi_osh;
   logic       spi_out_on;
   logic       spi_tog;
   shsp_wr_t   spi_wbuf;

   wire        spi_byte_end = (spi_bit == SHSP_BIT_LAST);
   wire [7:0]  spi_byte     = {spi_sh, spi_data_in};
   wire        spi_wr_fire  = spi_byte_end & spi_hdr & ~spi_rw & ~spi_wdone &
                              spi_sel;

   always_ff @(posedge serial_clock_in or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         spi_bit   <= 3'h0;
         spi_hdr   <= 1'b0;
         spi_rw    <= 1'b0;
         spi_sel   <= 1'b0;
         spi_wdone <= 1'b0;
         spi_addr  <= 7'h00;
         spi_sh    <= 7'h00;
      end
      else
      begin
         spi_sh  <= spi_byte[6:0];
         spi_bit <= spi_bit + 3'h1;
         if (spi_byte_end && !spi_hdr)
         begin
            spi_hdr  <= 1'b1;
            spi_rw   <= spi_byte[7];
            spi_addr <= spi_byte[6:0];
            spi_sel  <= shsp_addr_ok(spi_byte[6:0]);
         end
         else if (spi_byte_end && spi_rw)
            spi_addr <= shsp_next_addr(spi_addr);
         else if (spi_byte_end)
            spi_wdone <= 1'b1;
      end
   end

   // the toggle outlives the frame, so it only sees the system reset
   always_ff @(posedge serial_clock_in or negedge reset_n)
   begin
      if (!reset_n)
      begin
         spi_tog  <= 1'b0;
         spi_wbuf <= '0;
      end
      else if (spi_wr_fire)
      begin
         spi_tog  <= ~spi_tog;
         spi_wbuf <= '{addr: spi_addr, data: spi_byte};
      end
   end

   wire spi_load = spi_hdr & spi_rw & (spi_bit == 3'h0);

   always_ff @(negedge serial_clock_in or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         spi_osh    <= 8'h00;
         spi_out_on <= 1'b0;
      end
      else if (spi_load)
      begin
         spi_osh    <= link_rd_data;
         spi_out_on <= spi_sel;
      end
      else
         spi_osh <= {spi_osh[6:0], 1'b0};
   end

   // asynchronous read: the register file must answer within half a clock
   assign link_rd_addr = spi_addr;
   assign spi_data_out = spi_osh[7];
   assign spi_data_oe  = ~chip_select_n & spi_out_on;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: a bit is taken once stages two and three agree
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [5:0] pin_s3;
   logic [5:0] pin_f;
   logic [5:0] pin_q;
   logic       tog_seen;

   wire [5:0] pin_raw   = {spi_tog, addr_strap_1, addr_strap_0, chip_select_n,
                           scl_in, sda_in};
   wire [5:0] pin_agree = ~(pin_s2 ^ pin_s3);

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_s1 <= SHSP_PIN_RST;
         pin_s2 <= SHSP_PIN_RST;
         pin_s3 <= SHSP_PIN_RST;
         pin_f  <= SHSP_PIN_RST;
         pin_q  <= SHSP_PIN_RST;
      end
      else
      begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f  <= (pin_s3 & pin_agree) | (pin_f & ~pin_agree);
         pin_q  <= pin_f;
      end
   end

   assign i2c_mode = pin_f[SHSP_P_CS];

   wire scl_f     = pin_f[SHSP_P_SCL];
   wire sda_f     = pin_f[SHSP_P_SDA];
   wire scl_rise  = scl_f & ~pin_q[SHSP_P_SCL];
   wire scl_fall  = ~scl_f & pin_q[SHSP_P_SCL];
   wire i2c_start = scl_f & pin_q[SHSP_P_SCL] & pin_q[SHSP_P_SDA] & ~sda_f;
   wire i2c_stop  = scl_f & pin_q[SHSP_P_SCL] & ~pin_q[SHSP_P_SDA] & sda_f;
   wire [6:0] own_addr = {SHSP_I2C_BASE, pin_f[SHSP_P_S1], pin_f[SHSP_P_S0]};
   wire spi_wr_ev = (pin_f[SHSP_P_TOG] != tog_seen);

   ////////////////////////////////////////////////////////////////////////////
   // i2c slave, sampled at ref_clk; ten samples per bit at 2.5 MHz
   shsp_i2c_st_t st;
   logic [3:0]   i2c_bit;
   logic [7:0]   i2c_sh;
   logic [6:0]   i2c_ptr;
   logic         i2c_rw;
   logic         i2c_first;
   logic         i2c_oe;

   wire rx_full    = (i2c_bit == SHSP_BYTE_N);
   wire rx_shift   = scl_rise & ~rx_full & ((st == SHSP_ADDR) || (st == SHSP_RX));
   wire i2c_wr_ev  = (st == SHSP_RX) & scl_fall & rx_full & ~i2c_first;
   wire i2c_loadtx = scl_fall & ((st == SHSP_LOAD) || (st == SHSP_ACKA && i2c_rw));

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st        <= SHSP_IDLE;
         i2c_bit   <= 4'h0;
         i2c_sh    <= 8'h00;
         i2c_ptr   <= 7'h00;
         i2c_rw    <= 1'b0;
         i2c_first <= 1'b0;
         i2c_oe    <= 1'b0;
      end
      else if (!i2c_mode || i2c_stop)
      begin
         st     <= SHSP_IDLE;
         i2c_oe <= 1'b0;
      end
      else if (i2c_start)
      begin
         st      <= SHSP_ADDR;
         i2c_bit <= 4'h0;
         i2c_oe  <= 1'b0;
      end
      else if (rx_shift)
      begin
         i2c_sh  <= {i2c_sh[6:0], sda_f};
         i2c_bit <= i2c_bit + 4'h1;
      end
      else if (i2c_loadtx)
      begin
         st      <= SHSP_TX;
         i2c_sh  <= rd_data;
         i2c_oe  <= ~rd_data[7];
         i2c_bit <= 4'h1;
      end
      else
      begin
         case (st)
            SHSP_ADDR:
               if (scl_fall && rx_full)
               begin
                  if (i2c_sh[7:1] == own_addr)
                  begin
                     st        <= SHSP_ACKA;
                     i2c_oe    <= 1'b1;
                     i2c_rw    <= i2c_sh[0];
                     i2c_first <= 1'b1;
                  end
                  else
                     st <= SHSP_IDLE;
               end
            SHSP_ACKA:
               if (scl_fall)
               begin
                  st      <= SHSP_RX;
                  i2c_oe  <= 1'b0;
                  i2c_bit <= 4'h0;
               end
            SHSP_RX:
               if (scl_fall && rx_full)
               begin
                  st        <= SHSP_ACKW;
                  i2c_oe    <= 1'b1;
                  i2c_first <= 1'b0;
                  i2c_ptr   <= i2c_first ? i2c_sh[6:0] : shsp_next_addr(i2c_ptr);
               end
            SHSP_ACKW:
               if (scl_fall)
               begin
                  st      <= SHSP_RX;
                  i2c_oe  <= 1'b0;
                  i2c_bit <= 4'h0;
               end
            SHSP_TX:
               if (scl_fall && rx_full)
               begin
                  st      <= SHSP_RACK;
                  i2c_oe  <= 1'b0;
                  i2c_ptr <= shsp_next_addr(i2c_ptr);
               end
               else if (scl_fall)
               begin
                  i2c_oe  <= ~i2c_sh[6];
                  i2c_sh  <= {i2c_sh[6:0], 1'b0};
                  i2c_bit <= i2c_bit + 4'h1;
               end
            SHSP_RACK:
               if (scl_rise)
                  st <= sda_f ? SHSP_IDLE : SHSP_LOAD;
            default:
               st <= st;
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = i2c_oe;
   assign rd_addr = i2c_ptr;

   ////////////////////////////////////////////////////////////////////////////
   // register write port, shared by both slaves
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tog_seen <= 1'b0;
         wr_en    <= 1'b0;
         wr       <= '0;
      end
      else
      begin
         tog_seen <= pin_f[SHSP_P_TOG];
         wr_en    <= spi_wr_ev | i2c_wr_ev;
         wr       <= spi_wr_ev ? spi_wbuf : '{addr: i2c_ptr, data: i2c_sh};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_rx_last;
      (st == SHSP_RX) && scl_fall && rx_full;
   endsequence

   sequence s_tx_done;
      (st == SHSP_RACK) && scl_rise;
   endsequence

   a_mode_spi_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !i2c_mode |=> (st == SHSP_IDLE) && !sda_oe)
      else $error("i2c slave active in spi mode");

   a_addr_ack_match: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(st == SHSP_ACKA) |-> sda_oe && ($past(i2c_sh[7:1]) == own_addr))
      else $error("address ack without match");

   a_write_byte_ack: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_rx_last ##0 (i2c_mode && !i2c_stop && !i2c_start)
      |=> (st == SHSP_ACKW) && sda_oe)
      else $error("received byte not acknowledged");

   a_read_nack_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_tx_done ##0 sda_f ##0 i2c_mode |=> (st == SHSP_IDLE) && !sda_oe)
      else $error("transmission continued after no ack");

   a_read_ack_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st == SHSP_LOAD) && scl_fall && i2c_mode && !i2c_start && !i2c_stop
      |=> (st == SHSP_TX) && (i2c_sh == $past(rd_data)) && (sda_oe == !$past(rd_data[7])))
      else $error("next byte not loaded after ack");

   a_sda_drive_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(sda_oe) |-> !scl_f)
      else $error("sda driven while scl high");

   a_spi_write_xfer: assert property (@(posedge ref_clk) disable iff (!reset_n)
      spi_wr_ev |=> wr_en && (wr == $past(spi_wbuf)))
      else $error("spi write not passed to register port");

   a_spi_out_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
      chip_select_n |-> !spi_data_oe)
      else $error("spi output driven while deselected");

   a_spi_wrap_group: assert property (@(posedge serial_clock_in) disable iff (!link_rst_n)
      spi_hdr && spi_rw && spi_byte_end && (spi_addr == SHSP_G0_END)
      |=> spi_addr == SHSP_G0_BEG)
      else $error("auto increment did not wrap");

   a_spi_one_write: assert property (@(posedge serial_clock_in) disable iff (!link_rst_n)
      spi_wdone |=> $stable(spi_tog))
      else $error("second write in one frame");

   a_spi_read_load: assert property (@(negedge serial_clock_in) disable iff (!link_rst_n)
      spi_load |=> (spi_osh == $past(link_rd_data)) && (spi_out_on == $past(spi_sel)))
      else $error("read byte not presented");

endmodule : shsp_serial_port

/* shsp_pkg.sv */
package shsp_pkg;
   // Overview of operation
   // - chip select low at selection picks the SPI slave, high picks the I2C slave
   // - each SPI frame is 16 bits: read/write flag, 7-bit address, 8-bit data
   // - SPI input sampled on rising clock, output changed on falling clock, mode 3
   // - SPI transfer starts at chip select fall and ends at its rise
   // - SPI write takes the second byte only when the address is one of ours
   // - SPI write with under 16 clocks writes nothing; bits past 16 ignored
   // - one SPI write frame updates at most one register, no burst writes
   // - SPI read shifts out the addressed register MSB first after eight clocks
   // - continued SPI read clocks increment address; next byte follows 16th rising edge
   // - SPI data output goes high impedance when chip select rises
   // - address increment wraps 03H to 10H, 18H to 00H, 32H to 30H, 62H to 60H
   // - SPI address outside our groups leaves the device unselected, output released
   // - I2C slave runs Standard, Fast and High-speed bus rates up to 2.5 MHz
   // - after start the address byte is compared; a match is acknowledged
   // - during an I2C write every received byte is acknowledged
   // - I2C read sends byte, releases SDA; master ack continues, no ack stops
   // - I2C address is 00011 followed by the two strap levels, 0CH to 0FH
   // - first I2C byte LSB is direction: one reads, zero writes
   // - SDA changes only while SCL low, except start and stop conditions

   localparam logic [4:0] SHSP_I2C_BASE = 5'h03;
   localparam logic [6:0] SHSP_G0_BEG   = 7'h00;
   localparam logic [6:0] SHSP_G0_GAP   = 7'h03;
   localparam logic [6:0] SHSP_G0_JUMP  = 7'h10;
   localparam logic [6:0] SHSP_G0_END   = 7'h18;
   localparam logic [6:0] SHSP_G1_BEG   = 7'h30;
   localparam logic [6:0] SHSP_G1_END   = 7'h32;
   localparam logic [6:0] SHSP_G1_TOP   = 7'h37;
   localparam logic [6:0] SHSP_G2_BEG   = 7'h60;
   localparam logic [6:0] SHSP_G2_END   = 7'h62;
   localparam logic [2:0] SHSP_BIT_LAST = 3'h7;
   localparam logic [3:0] SHSP_BYTE_N   = 4'h8;
   // synchronised pin vector: {toggle, strap1, strap0, cs_n, scl, sda}
   localparam int         SHSP_P_SDA    = 0;
   localparam int         SHSP_P_SCL    = 1;
   localparam int         SHSP_P_CS     = 2;
   localparam int         SHSP_P_S0     = 3;
   localparam int         SHSP_P_S1     = 4;
   localparam int         SHSP_P_TOG    = 5;
   localparam logic [5:0] SHSP_PIN_RST  = 6'h07;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } shsp_wr_t;

   typedef enum logic [7:0] {
      SHSP_IDLE = 8'h01,
      SHSP_ADDR = 8'h02,
      SHSP_ACKA = 8'h04,
      SHSP_RX   = 8'h08,
      SHSP_ACKW = 8'h10,
      SHSP_TX   = 8'h20,
      SHSP_RACK = 8'h40,
      SHSP_LOAD = 8'h80
   } shsp_i2c_st_t;

   function automatic logic [6:0] shsp_next_addr(input logic [6:0] a);
      logic [6:0] n;
      n = a + 7'h01;
      if (a == SHSP_G0_GAP)
         n = SHSP_G0_JUMP;
      else if (a == SHSP_G0_END)
         n = SHSP_G0_BEG;
      else if (a == SHSP_G1_END)
         n = SHSP_G1_BEG;
      else if (a == SHSP_G2_END)
         n = SHSP_G2_BEG;
      return n;
   endfunction : shsp_next_addr

   function automatic logic shsp_addr_ok(input logic [6:0] a);
      return (a <= SHSP_G0_END) || (a >= SHSP_G1_BEG && a <= SHSP_G1_TOP) ||
             (a >= SHSP_G2_BEG && a <= SHSP_G2_END);
   endfunction : shsp_addr_ok
endpackage : shsp_pkg

/* shsp_host_model.sv */
`timescale 1ns/1ps
module shsp_host_model
(
   // spi master pins
   output logic      sck,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe,
   // i2c master pins, sda high means released to the pull-up
   output logic      scl,
   output logic      sda,
   input  wire logic sda_line
);
   logic [63:0] rx;
   logic        oe_any;

   initial
   begin
      sck = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
      scl = 1'b1;
      sda = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic spi_xfer(input logic [15:0] tx, input int n);
      rx = '0;
      oe_any = 1'b0;
      #13 cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         #40 sck = 1'b0;
         mosi = (i < 16) ? tx[15-i] : i[0];
         #40 sck = 1'b1;
         rx = {rx[62:0], miso};
         oe_any = oe_any | miso_oe;
      end
      #40 cs_n = 1'b1;
      // let the deselect settle before the caller looks at the output enable
      #40;
   endtask : spi_xfer

   task automatic i2c_start(input int q);
      sda = 1'b1;
      #q scl = 1'b1;
      #q sda = 1'b0;
      #q scl = 1'b0;
   endtask : i2c_start

   task automatic i2c_stop(input int q);
      #q sda = 1'b0;
      #q scl = 1'b1;
      #q sda = 1'b1;
      #q;
   endtask : i2c_stop

   task automatic i2c_bit(input logic b, input int q, output logic s);
      #q sda = b;
      #q scl = 1'b1;
      #q s = sda_line;
      #q scl = 1'b0;
   endtask : i2c_bit

   // eight bits out (or released for a read), then the ninth clock
   task automatic i2c_byte(input logic [7:0] b, input logic mack, input int q,
                           output logic [7:0] got, output logic ack);
      for (int i = 7; i >= 0; i--)
         i2c_bit(b[i], q, got[i]);
      i2c_bit(mack, q, ack);
   endtask : i2c_byte
endmodule : shsp_host_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import shsp_pkg::*;
   logic       ref_clk, reset_n, s0, s1;
   logic       sck, cs_n, mosi, miso, miso_oe, scl, m_sda, sda_out, sda_oe;
   logic       wr_en, i2c_mode;
   shsp_wr_t   wr, last_wr;
   logic [6:0] rd_addr, link_rd_addr;
   logic [7:0] regs [128];
   int         wr_cnt, err_count, tests_run;
   wire        sda_line = m_sda & ~(sda_oe & ~sda_out);

   shsp_serial_port DUT (.ref_clk(ref_clk), .reset_n(reset_n), .serial_clock_in(sck),
      .chip_select_n(cs_n), .spi_data_in(mosi), .spi_data_out(miso), .spi_data_oe(miso_oe),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_0(s0), .addr_strap_1(s1), .wr_en(wr_en), .wr(wr), .rd_addr(rd_addr),
      .rd_data(regs[rd_addr]), .i2c_mode(i2c_mode), .link_rd_addr(link_rd_addr),
      .link_rd_data(regs[link_rd_addr]));
   shsp_host_model host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .scl(scl), .sda(m_sda), .sda_line(sda_line));

   // register file stand-in; contents start as address xor A5
   initial
   begin
      wr_cnt = 0;
      for (int i = 0; i < 128; i++)
         regs[i] = 8'(i) ^ 8'hA5;
   end
   always @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         regs[wr.addr] <= wr.data;
         last_wr <= wr;
         wr_cnt <= wr_cnt + 1;
      end
   end

   function automatic logic [15:0] exp_reg(input logic [6:0] a);
      return {8'h00, {1'b0, a} ^ 8'hA5};
   endfunction : exp_reg

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////////////
   // short, long, and foreign-address frames
   task automatic t_spi_write();
      logic [6:0] a [4] = '{7'h11, 7'h12, 7'h13, 7'h40};
      int         n [4] = '{16, 20, 15, 16};
      int         c;
      for (int k = 0; k < 4; k++)
      begin
         c = wr_cnt;
         host.spi_xfer({1'b0, a[k], 8'h5A ^ 8'(k)}, n[k]);
         repeat (20) @(posedge ref_clk);
         check("spi_wr_count", 16'(wr_cnt - c), (k < 2) ? 16'h0001 : 16'h0000);
         if (k < 2)
            check("spi_wr_word", 16'(last_wr), {1'b0, a[k], 8'h5A ^ 8'(k)});
      end
   endtask : t_spi_write

   task automatic t_spi_read();
      // reserved addresses are never used by the host
      logic [6:0] a  [5] = '{7'h02, 7'h03, 7'h18, 7'h32, 7'h62};
      logic [6:0] nx [5] = '{7'h03, 7'h10, 7'h00, 7'h30, 7'h60};
      for (int k = 0; k < 5; k++)
      begin
         host.spi_xfer({1'b1, a[k], 8'h00}, 24);
         check("spi_rd_first", {8'h00, host.rx[15:8]}, exp_reg(a[k]));
         check("spi_rd_next", {8'h00, host.rx[7:0]}, exp_reg(nx[k]));
         check("spi_oe_release", 16'(miso_oe), 16'h0000);
      end
      host.spi_xfer({1'b1, 7'h40, 8'h00}, 24);
      check("spi_unselected_oe", 16'(host.oe_any), 16'h0000);
   endtask : t_spi_read

   // one write per bus rate, each with its own strap setting
   task automatic t_i2c_write();
      int         q [3] = '{2500, 625, 100};
      logic [7:0] g;
      logic       ack;
      int         c;
      // mode select passes the pin synchroniser first
      repeat (8) @(posedge ref_clk);
      check("i2c_mode", 16'(i2c_mode), 16'h0001);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge ref_clk);
         s0 <= k[0];
         s1 <= k[1];
         repeat (8) @(posedge ref_clk);
         c = wr_cnt;
         host.i2c_start(q[k]);
         host.i2c_byte({5'h03, k[1], k[0], 1'b0}, 1'b1, q[k], g, ack);
         check("i2c_addr_ack", 16'(ack), 16'h0000);
         host.i2c_byte(8'h13 + 8'(k), 1'b1, q[k], g, ack);
         check("i2c_ptr_ack", 16'(ack), 16'h0000);
         host.i2c_byte(8'hC0 | 8'(k), 1'b1, q[k], g, ack);
         check("i2c_data_ack", 16'(ack), 16'h0000);
         host.i2c_stop(q[k]);
         check("i2c_wr_count", 16'(wr_cnt - c), 16'h0001);
         check("i2c_wr_word", 16'(last_wr), {1'b0, 7'h13 + 7'(k), 8'hC0 | 8'(k)});
      end
      host.i2c_start(625);
      host.i2c_byte({5'h03, 2'b01, 1'b0}, 1'b1, 625, g, ack);
      check("i2c_foreign_nack", 16'(ack), 16'h0001);
      host.i2c_stop(625);
   endtask : t_i2c_write

   task automatic t_i2c_read();
      logic [7:0] g;
      logic       ack;
      @(posedge ref_clk);
      s0 <= 1'b1;
      s1 <= 1'b1;
      repeat (8) @(posedge ref_clk);
      host.i2c_start(625);
      host.i2c_byte(8'h1E, 1'b1, 625, g, ack);
      host.i2c_byte(8'h18, 1'b1, 625, g, ack);
      host.i2c_start(625);
      host.i2c_byte(8'h1F, 1'b1, 625, g, ack);
      check("i2c_rd_addr_ack", 16'(ack), 16'h0000);
      host.i2c_byte(8'hFF, 1'b0, 625, g, ack);
      check("i2c_rd_first", {8'h00, g}, exp_reg(7'h18));
      host.i2c_byte(8'hFF, 1'b1, 625, g, ack);
      check("i2c_rd_next", {8'h00, g}, exp_reg(7'h00));
      #1250;
      check("i2c_rd_release", 16'(sda_oe), 16'h0000);
      host.i2c_stop(625);
   endtask : t_i2c_read

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial
   begin
      reset_n = 1'b0;
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      t_spi_write();
      t_spi_read();
      t_i2c_write();
      t_i2c_read();
      complete_run();
   end

   // whole run needs just over half a millisecond
   initial
   begin
      #3000000;
      err_count++;
      complete_run();
   end
endmodule : tb_top
